//--- wdt_top.sv
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module wdt_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // axi4-lite write address and data
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // oscillator and configuration
  input  wire logic        LOW_FREQ_INTERNAL_OSC,
  input  wire logic [1:0]  WDOG_MODE_CFG,
  input  wire logic        CRYSTAL_CLOCK_SEL,
  // core and system control
  input  wire logic        CLEAR_WATCHDOG_INSTR,
  input  wire logic        SLEEP_ENTER,
  input  wire logic        SLEEP_EXIT,
  input  wire logic        OSC_FAIL,
  input  wire logic        OSC_STARTUP_TIMER_RUN,
  input  wire logic        OSC_STARTUP_TIMER_DONE,
  // results
  output logic             WDOG_RESET,
  output logic             WDOG_WAKE,
  output logic             TIMEOUT_FLAG_N,
  output logic             POWERDOWN_FLAG_N,
  output logic             IRQ
);

  wdt_tick_if          tk_if ();
  wdt_pkg::wdt_pwr_t   pwr;
  wdt_pkg::wdt_pwr_t   next_pwr;
  logic [4:0]          period_sel;
  logic                sw_en;
  logic [1:0]          status;
  logic [1:0]          irq_en;
  logic [23:0]         cnt;
  logic [23:0]         limit;
  logic                wd_en;
  logic                leave_sleep;
  logic                enter_sleep;
  logic                clr_any;
  logic                to_evt;
  logic                aw_held;
  logic                w_held;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                write_go;
  logic                wr_ctrl;
  logic                wr_clear;
  logic                wr_irq_en;
  logic [31:0]         rd_word;
  logic                rd_hit;

  // base ticks from the oscillator pin, synchronised into clk
  wdt_lfsync u_sync (
    .CLK    (CLK),
    .ARST_N (ARST_N),
    .osc_in (LOW_FREQ_INTERNAL_OSC),
    .tk     (tk_if.src)
  );

  // ---- power state ----

  // sleep entry and exit, crystal exit waits for the start-up timer
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      wdt_pkg::PWR_AWAKE: begin
        if (SLEEP_ENTER)
          next_pwr = wdt_pkg::PWR_ASLEEP;
      end
      wdt_pkg::PWR_ASLEEP: begin
        if (SLEEP_EXIT || to_evt) begin
          if (CRYSTAL_CLOCK_SEL)
            next_pwr = wdt_pkg::PWR_OST_HOLD;
          else
            next_pwr = wdt_pkg::PWR_AWAKE;
        end
      end
      wdt_pkg::PWR_OST_HOLD: begin
        if (OSC_STARTUP_TIMER_DONE)
          next_pwr = wdt_pkg::PWR_AWAKE;
      end
      default: next_pwr = wdt_pkg::PWR_AWAKE;
    endcase
  end

  // power state register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pwr <= wdt_pkg::PWR_AWAKE;
    end else begin
      pwr <= next_pwr;
    end
  end

  assign enter_sleep = (pwr == wdt_pkg::PWR_AWAKE) && SLEEP_ENTER;
  // only a requested exit feeds the clear; a timeout wake already empties
  // the count on its own, and using next_pwr here would loop through to_evt
  assign leave_sleep = (pwr == wdt_pkg::PWR_ASLEEP) && SLEEP_EXIT;

  // ---- enable decode and period limit ----

  // operating mode table
  always_comb begin
    case (WDOG_MODE_CFG)
      wdt_pkg::MODE_ALWAYS: wd_en = 1'b1;
      wdt_pkg::MODE_NOSLP:
        wd_en = (pwr != wdt_pkg::PWR_ASLEEP);
      wdt_pkg::MODE_SW:     wd_en = sw_en;
      wdt_pkg::MODE_OFF:    wd_en = 1'b0;
      default:              wd_en = 1'b0;
    endcase
  end

  // prescale of 2^(code+5); reserved codes fall back to 1:32
  always_comb begin
    if (period_sel <= wdt_pkg::PS_MAX_CODE)
      limit = 24'h000001 << (period_sel + wdt_pkg::PS_EXP_BASE);
    else
      limit = wdt_pkg::LIMIT_MIN;
  end

  // every condition other than reset and the timeout restart that empties the count; the divider select has no say
  assign clr_any = CLEAR_WATCHDOG_INSTR | enter_sleep | leave_sleep
                 | OSC_FAIL | ~wd_en | OSC_STARTUP_TIMER_RUN
                 | (pwr == wdt_pkg::PWR_OST_HOLD);

  assign to_evt = tk_if.tick & ~clr_any & (cnt == limit - 24'h000001);

  // ---- prescaler count ----

  // count base ticks, restart after the limit; enabled sleep keeps counting
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt <= 24'h000000;
    end else if (clr_any) begin
      cnt <= 24'h000000;
    end else if (to_evt) begin
      cnt <= 24'h000000;
    end else if (tk_if.tick) begin
      cnt <= cnt + 24'h000001;
    end
  end

  // ---- timeout results ----

  // awake timeout resets the system, asleep timeout wakes it
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WDOG_RESET <= 1'b0;
      WDOG_WAKE  <= 1'b0;
    end else begin
      WDOG_RESET <= to_evt & (pwr != wdt_pkg::PWR_ASLEEP);
      WDOG_WAKE  <= to_evt & (pwr == wdt_pkg::PWR_ASLEEP);
    end
  end

  // time-out and power-down flags, both active low
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TIMEOUT_FLAG_N   <= 1'b1;
      POWERDOWN_FLAG_N <= 1'b1;
    end else if (to_evt) begin
      TIMEOUT_FLAG_N   <= 1'b0;
      POWERDOWN_FLAG_N <= (pwr != wdt_pkg::PWR_ASLEEP);
    end else if (CLEAR_WATCHDOG_INSTR) begin
      TIMEOUT_FLAG_N   <= 1'b1;
      POWERDOWN_FLAG_N <= 1'b1;
    end else if (enter_sleep) begin
      TIMEOUT_FLAG_N   <= 1'b1;
      POWERDOWN_FLAG_N <= 1'b0;
    end
  end

  // ---- register bus, write side ----

  assign write_go  = aw_held & w_held & ~S_AXI_BVALID;
  assign wr_ctrl   = write_go & (aw_addr == wdt_pkg::ADDR_CTRL) & w_strb[0];
  assign wr_clear  = write_go & (aw_addr == wdt_pkg::ADDR_CLEAR) & w_strb[0];
  assign wr_irq_en = write_go & (aw_addr == wdt_pkg::ADDR_IRQ_EN) & w_strb[0];

  // write address channel
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_AWREADY <= 1'b0;
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_held       <= 1'b1;
        aw_addr       <= S_AXI_AWADDR;
      end else begin
        if (write_go)
          aw_held <= 1'b0;
        if (!aw_held && !S_AXI_BVALID)
          S_AXI_AWREADY <= 1'b1;
      end
    end
  end

  // write data channel
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_WREADY <= 1'b0;
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
    end else begin
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        w_held       <= 1'b1;
        w_data       <= S_AXI_WDATA;
        w_strb       <= S_AXI_WSTRB;
      end else begin
        if (write_go)
          w_held <= 1'b0;
        if (!w_held && !S_AXI_BVALID)
          S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // write response, error for an unmapped offset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= wdt_pkg::RESP_OKAY;
    end else if (write_go) begin
      S_AXI_BVALID <= 1'b1;
      case (aw_addr)
        wdt_pkg::ADDR_CTRL, wdt_pkg::ADDR_CLEAR, wdt_pkg::ADDR_IRQ_EN,
        wdt_pkg::ADDR_STATUS, wdt_pkg::ADDR_COUNT:
          S_AXI_BRESP <= wdt_pkg::RESP_OKAY;
        default:
          S_AXI_BRESP <= wdt_pkg::RESP_SLVERR;
      endcase
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ---- registers ----

  // watchdog_control: period select and software enable
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      period_sel <= wdt_pkg::PS_RESET;
      sw_en      <= wdt_pkg::SWEN_RESET;
    end else if (wr_ctrl) begin
      period_sel <= w_data[wdt_pkg::CTRL_PS_MSB:wdt_pkg::CTRL_PS_LSB];
      sw_en      <= w_data[wdt_pkg::CTRL_EN_BIT];
    end
  end

  // sticky timeout events, a new event beats a same-cycle clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= wdt_pkg::STAT_RESET;
    end else begin
      status[wdt_pkg::STAT_RST_BIT] <=
        (to_evt & (pwr != wdt_pkg::PWR_ASLEEP))
        | (status[wdt_pkg::STAT_RST_BIT]
           & ~(wr_clear & w_data[wdt_pkg::STAT_RST_BIT]));
      status[wdt_pkg::STAT_WAKE_BIT] <=
        (to_evt & (pwr == wdt_pkg::PWR_ASLEEP))
        | (status[wdt_pkg::STAT_WAKE_BIT]
           & ~(wr_clear & w_data[wdt_pkg::STAT_WAKE_BIT]));
    end
  end

  // interrupt enables and level interrupt
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_en <= wdt_pkg::IEN_RESET;
      IRQ    <= 1'b0;
    end else begin
      if (wr_irq_en)
        irq_en <= w_data[1:0];
      IRQ <= |(status & irq_en);
    end
  end

  // ---- register bus, read side ----

  // read mux; unused control bits read zero
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (S_AXI_ARADDR)
      wdt_pkg::ADDR_CTRL:
        rd_word = {26'h0000000, period_sel, sw_en};
      wdt_pkg::ADDR_STATUS: rd_word = {30'h00000000, status};
      wdt_pkg::ADDR_CLEAR:  rd_word = 32'h00000000;
      wdt_pkg::ADDR_IRQ_EN: rd_word = {30'h00000000, irq_en};
      wdt_pkg::ADDR_COUNT:  rd_word = {8'h00, cnt};
      default:              rd_hit  = 1'b0;
    endcase
  end

  // read address and data channels
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= wdt_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_word;
      S_AXI_RRESP   <= rd_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
    end else if (!S_AXI_RVALID) begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ---- checks ----

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_timeout_due;
    tk_if.tick && !clr_any && (cnt == limit - 24'h000001);
  endsequence

  sequence s_asleep_timeout;
    (pwr == wdt_pkg::PWR_ASLEEP) ##0 s_timeout_due;
  endsequence

  a_mode_off_clear: assert property (
    (WDOG_MODE_CFG == wdt_pkg::MODE_OFF) |=> (cnt == 24'h000000)
  ) else $error("count moved with watchdog off");

  a_always_on_run: assert property (
    (WDOG_MODE_CFG == wdt_pkg::MODE_ALWAYS) |-> wd_en
  ) else $error("always-on mode not running");

  a_noslp_sleep_off: assert property (
    (WDOG_MODE_CFG == wdt_pkg::MODE_NOSLP) && (pwr == wdt_pkg::PWR_ASLEEP)
    |=> (cnt == 24'h000000)
  ) else $error("count moved asleep in mode 10");

  a_sw_mode_follow: assert property (
    (WDOG_MODE_CFG == wdt_pkg::MODE_SW) |-> (wd_en == sw_en)
  ) else $error("software mode ignores enable");

  a_reserved_min: assert property (
    (period_sel > wdt_pkg::PS_MAX_CODE) |-> (limit == 24'h000020)
  ) else $error("reserved code not minimum");

  a_clear_instr_zero: assert property (
    CLEAR_WATCHDOG_INSTR |=> (cnt == 24'h000000)
  ) else $error("clear instruction did not clear");

  a_awake_reset_out: assert property (
    (pwr != wdt_pkg::PWR_ASLEEP) ##0 s_timeout_due
    |=> WDOG_RESET && !WDOG_WAKE && !TIMEOUT_FLAG_N && (cnt == 24'h000000)
  ) else $error("awake timeout did not reset");

  a_sleep_wake_out: assert property (
    s_asleep_timeout |=> WDOG_WAKE && !WDOG_RESET && !POWERDOWN_FLAG_N
  ) else $error("sleep timeout did not wake");

  a_ost_hold_zero: assert property (
    (pwr == wdt_pkg::PWR_OST_HOLD) |=> (cnt == 24'h000000)
  ) else $error("count moved before start-up done");

  a_ctrl_high_zero: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == wdt_pkg::ADDR_CTRL)
    |=> S_AXI_RVALID && (S_AXI_RDATA[31:6] == 26'h0000000)
  ) else $error("control upper bits not zero");

  a_tick_counts: assert property (
    tk_if.tick && wd_en && !clr_any && (cnt < limit - 24'h000001)
    |=> (cnt == $past(cnt) + 24'h000001)
  ) else $error("enabled tick did not advance count");

endmodule

//--- wdt_pkg.sv
package wdt_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLEAR  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
  localparam logic [7:0] ADDR_COUNT  = 8'h10;

  // watchdog_control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int CTRL_PS_MSB = 5;

  // reset values
  localparam logic [4:0] PS_RESET    = 5'h0B;
  localparam logic       SWEN_RESET  = 1'b0;
  localparam logic [1:0] STAT_RESET  = 2'h0;
  localparam logic [1:0] IEN_RESET   = 2'h0;

  // period select decode
  localparam logic [4:0]  PS_MAX_CODE = 5'h12;
  localparam logic [4:0]  PS_EXP_BASE = 5'h05;
  localparam logic [23:0] LIMIT_MIN   = 24'h000020;

  // status bit positions
  localparam int STAT_RST_BIT  = 0;
  localparam int STAT_WAKE_BIT = 1;

  // configuration mode codes
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SW     = 2'h1;
  localparam logic [1:0] MODE_NOSLP  = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // power state of the device as the watchdog sees it
  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_ASLEEP,
    PWR_OST_HOLD
  } wdt_pwr_t;

endpackage

//--- wdt_tick_if.sv
`timescale 1ns/1ps
interface wdt_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

//--- wdt_lfsync.sv
`timescale 1ns/1ps
module wdt_lfsync (
  // clock and reset
  input  wire logic  CLK,
  input  wire logic  ARST_N,
  // raw low-frequency oscillator
  input  wire logic  osc_in,
  // one-cycle pulse per oscillator rising edge
  wdt_tick_if.src    tk
);

  logic sync1;
  logic sync2;
  logic sync3;

  // two-flop synchroniser, then a third stage for edge detection
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= osc_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // rising edge of the oscillator becomes one base tick enable
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tk.tick <= 1'b0;
    end else begin
      tk.tick <= sync2 & ~sync3;
    end
  end

endmodule

//--- wdt_core_model.sv
`timescale 1ns/1ps
// core-side model: slow oscillator pin plus the reset and wake takers
module wdt_core_model (
  // clock
  input  wire logic        clk,
  // oscillator request and pin
  input  wire logic [31:0] want,
  output logic             osc,
  output logic [31:0]      rises,
  // watchdog results
  input  wire logic        wdog_reset,
  input  wire logic        wdog_wake,
  output logic [31:0]      resets,
  output logic [31:0]      wakes
);
  logic [1:0]  phase  = 2'h0;
  logic        pin    = 1'h0;
  logic [31:0] n_rise = 32'h0;
  logic [31:0] n_rst  = 32'h0;
  logic [31:0] n_wake = 32'h0;

  assign osc    = pin;
  assign rises  = n_rise;
  assign resets = n_rst;
  assign wakes  = n_wake;

  // pin flips every four clocks while rises are owed, else falls and holds low
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    if (phase == 2'h3) begin
      if (pin) begin
        pin <= 1'h0;
      end else if (n_rise != want) begin
        pin    <= 1'h1;
        n_rise <= n_rise + 32'h1;
      end
    end
  end

  // every awake timeout is taken as a system reset, every sleep one a wake
  always @(posedge clk) begin
    if (wdog_reset === 1'h1) begin
      n_rst <= n_rst + 32'h1;
    end
    if (wdog_wake === 1'h1) begin
      n_wake <= n_wake + 32'h1;
    end
  end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("unexpected at %0t ns: got %0h expected %0h", \
               $time, (got), (exp)); \
    end \
  end
module testbench;
  logic        clk, arst_n, xtal;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, base, rbase;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp, mode;
  logic [5:0]  ev;
  logic        wd_rst, wd_wake, to_n, pd_n, irq, osc;
  logic [31:0] want, rises, resets, wakes;
  logic [4:0]  ps_code [4] = '{5'h00, 5'h01, 5'h13, 5'h1F};
  int          ps_lim [4]  = '{32, 64, 32, 32};
  logic [1:0]  md [4]      = '{2'h0, 2'h1, 2'h1, 2'h2};
  logic        en [4]      = '{1'h1, 1'h0, 1'h1, 1'h0};
  logic [31:0] cnt [4]     = '{32'h0, 32'h0, 32'h8, 32'h8};
  int          failures, checks;
  int          clr_k [3]   = '{0, 3, 4};

  wdt_top DUT (
    .CLK(clk), .ARST_N(arst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .LOW_FREQ_INTERNAL_OSC(osc), .WDOG_MODE_CFG(mode),
    .CRYSTAL_CLOCK_SEL(xtal), .CLEAR_WATCHDOG_INSTR(ev[0]),
    .SLEEP_ENTER(ev[1]), .SLEEP_EXIT(ev[2]), .OSC_FAIL(ev[3]),
    .OSC_STARTUP_TIMER_RUN(ev[4]), .OSC_STARTUP_TIMER_DONE(ev[5]),
    .WDOG_RESET(wd_rst), .WDOG_WAKE(wd_wake), .TIMEOUT_FLAG_N(to_n),
    .POWERDOWN_FLAG_N(pd_n), .IRQ(irq)
  );

  wdt_core_model core (
    .clk(clk), .want(want), .osc(osc), .rises(rises),
    .wdog_reset(wd_rst), .wdog_wake(wd_wake), .resets(resets), .wakes(wakes)
  );

  // system clock, 100 ns period
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop;
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    aw_d = 1'h0;
    w_d  = 1'h0;
    do begin
      @(posedge clk);
      if (!aw_d && awready === 1'h1) begin
        awvalid <= 1'h0;
        aw_d = 1'h1;
      end
      if (!w_d && wready === 1'h1) begin
        wvalid <= 1'h0;
        w_d = 1'h1;
      end
    end while (!(aw_d && w_d));
    while (bvalid !== 1'h1) @(posedge clk);
    rsp = bresp;
    bready <= 1'h0;
  endtask

  // bus read, data and response taken at the rvalid edge
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'h0;
    `CHK(rd, e)
  endtask

  // ask the model for n more oscillator rises, then let ticks land
  task automatic rise(input int n);
    @(posedge clk);
    want <= want + 32'(n);
    do @(posedge clk); while (rises !== want);
    repeat (6) @(posedge clk);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'h1;
    @(posedge clk);
    ev <= 6'h00;
    repeat (2) @(posedge clk);
  endtask

  task automatic do_reset;
    arst_n <= 1'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    repeat (2) @(posedge clk);
  endtask

  // reset values, field layout and unmapped accesses
  task automatic t_regs;
    rchk(wdt_pkg::ADDR_CTRL, 32'h16);
    rchk(wdt_pkg::ADDR_STATUS, 32'h0);
    rchk(8'h20, 32'h0);
    `CHK(rsp, wdt_pkg::RESP_SLVERR)
    wr(8'h20, 32'hFFFFFFFF);
    `CHK(rsp, wdt_pkg::RESP_SLVERR)
    wr(wdt_pkg::ADDR_CTRL, 32'hFF);
    `CHK(rsp, wdt_pkg::RESP_OKAY)
    rchk(wdt_pkg::ADDR_CTRL, 32'h3F);
    wr(wdt_pkg::ADDR_CTRL, 32'h0);
  endtask

  // awake timeout at the exact count, then interrupt mask and clear
  task automatic t_awake;
    wr(wdt_pkg::ADDR_IRQ_EN, 32'h3);
    mode <= wdt_pkg::MODE_ALWAYS;
    pulse(0);
    base = resets;
    rise(31);
    `CHK(resets, base)
    rise(1);
    `CHK(resets, base + 32'h1)
    `CHK(to_n, 1'h0)
    rchk(wdt_pkg::ADDR_COUNT, 32'h0);
    rchk(wdt_pkg::ADDR_STATUS, 32'h1);
    `CHK(irq, 1'h1)
    wr(wdt_pkg::ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h0)
    wr(wdt_pkg::ADDR_IRQ_EN, 32'h1);
    wr(wdt_pkg::ADDR_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h0)
    rchk(wdt_pkg::ADDR_STATUS, 32'h0);
  endtask

  // period codes: lowest, next, first and last reserved
  task automatic t_codes;
    for (int i = 0; i < 4; i++) begin
      wr(wdt_pkg::ADDR_CTRL, {26'h0, ps_code[i], 1'h0});
      pulse(0);
      base = resets;
      rise(ps_lim[i] - 1);
      `CHK(resets, base)
      rise(1);
      `CHK(resets, base + 32'h1)
    end
  endtask

  // mode and software enable table, then disable clears the count
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      wr(wdt_pkg::ADDR_CTRL, {31'h0, en[i]});
      mode <= md[i];
      pulse(0);
      rise(8);
      rchk(wdt_pkg::ADDR_COUNT, cnt[i]);
    end
    mode <= wdt_pkg::MODE_OFF;
    repeat (2) @(posedge clk);
    rchk(wdt_pkg::ADDR_COUNT, 32'h0);
  endtask

  // sleep entry and exit in always-on, no-sleep and software modes, wake on timeout, crystal hold
  task automatic t_sleep;
    wr(wdt_pkg::ADDR_CLEAR, 32'h3);
    mode <= wdt_pkg::MODE_ALWAYS;
    xtal <= 1'h0;
    pulse(0);
    rise(5);
    pulse(1);
    `CHK({to_n, pd_n}, 2'h2)
    rchk(wdt_pkg::ADDR_COUNT, 32'h0);
    base  = wakes;
    rbase = resets;
    rise(31);
    rchk(wdt_pkg::ADDR_COUNT, 32'h1F);
    rise(1);
    `CHK(wakes, base + 32'h1)
    `CHK(resets, rbase)
    `CHK({to_n, pd_n}, 2'h0)
    rchk(wdt_pkg::ADDR_STATUS, 32'h2);
    mode <= wdt_pkg::MODE_NOSLP;
    pulse(1);
    rise(40);
    `CHK(wakes, base + 32'h1)
    rchk(wdt_pkg::ADDR_COUNT, 32'h0);
    pulse(2);
    rise(8);
    rchk(wdt_pkg::ADDR_COUNT, 32'h8);
    mode <= wdt_pkg::MODE_ALWAYS;
    xtal <= 1'h1;
    pulse(1);
    pulse(2);
    rise(8);
    rchk(wdt_pkg::ADDR_COUNT, 32'h0);
    pulse(5);
    rise(8);
    rchk(wdt_pkg::ADDR_COUNT, 32'h8);
    xtal <= 1'h0;
    mode <= wdt_pkg::MODE_SW;
    wr(wdt_pkg::ADDR_CTRL, 32'h1);
    pulse(1);
    rise(8);
    rchk(wdt_pkg::ADDR_COUNT, 32'h8);
    pulse(2);
  endtask

  // clear instruction, oscillator fail, start-up timer, second reset
  task automatic t_clears;
    mode <= wdt_pkg::MODE_ALWAYS;
    for (int i = 0; i < 3; i++) begin
      rise(5);
      pulse(clr_k[i]);
      rchk(wdt_pkg::ADDR_COUNT, 32'h0);
    end
    pulse(0);
    `CHK({to_n, pd_n}, 2'h3)
    rise(5);
    do_reset;
    rchk(wdt_pkg::ADDR_CTRL, 32'h16);
    rchk(wdt_pkg::ADDR_COUNT, 32'h0);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {arst_n, xtal, mode, ev, want} = 42'h0;
    wstrb    = 4'hF;
    failures = 0;
    checks   = 0;
    do_reset;
    t_regs;
    t_awake;
    t_codes;
    t_modes;
    t_sleep;
    t_clears;
    report_and_stop;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule
